// file: inc/tqd_pkg.sv
// tqd_pkg: constants and carriers of the quadrature decode and irq block
// assumes one 10 MHz clock and a plain register port with one-cycle strobes
// Notes on behaviour
// - mode 2 counts on the qualifying a edge: up if b high, down if low.
// - mode 3: a fall with b high counts up, b fall with a high down.
// - mode 4: b edges count by level of a; a edges ignored.
// - full variant: compare, overflow, underflow sources; reduced: compare, overflow only.
// - each source has its own status flag and its own enable bit.
// - an event sets its flag; request stands while flag and enable are 1.
// - clearing the flag to 0 withdraws the request; no other acknowledge.
// - fixed priority: compare a to d, overflow, underflow; channel 0 first.
// - compare requests: eight in full variant, four in reduced variant.
// - overflow requests, one per channel: three full, two reduced.
// - underflow requests only in full variant, channels 1 and 2.
// - only the eight compare sources may start the transfer controller; full variant only, as the reduced variant never requests a transfer.
// - compare a event with converter trigger enabled sends a conversion start.
// - conversion starts come only from compare a, one per channel.
// - phase counting on channels 1 and 2 only, from their phase pins; full variant only, as the reduced variant ignores mode writes.
// - overflow counting up sets overflow flag; underflow counting down sets underflow.
// - software clears a flag by writing 0 after reading 1; transfer clears it too.
package tqd_pkg;
    localparam int CNT_W = 16;
    localparam int NSRC = 13;
    localparam int NCMP = 8;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CNT1 = 8'h0c;
    localparam logic [7:0] OFS_CNT2 = 8'h10;
    localparam logic [7:0] OFS_ADC_EN = 8'h14;
    localparam logic [7:0] OFS_PEND = 8'h18;
    // reset values
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [12:0] RST_IRQ_EN = 13'h0000;
    localparam logic [12:0] RST_STATUS = 13'h0000;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [2:0] RST_ADC_EN = 3'h0;
    // field positions in the mode register
    localparam int POS_MODE1 = 0;
    localparam int POS_MODE2 = 2;
    localparam int POS_DIR1 = 4;
    localparam int POS_DIR2 = 5;
    // source positions in status, enable and request vectors, priority order
    localparam int POS_C0OV = 4;
    localparam int POS_C1A = 5;
    localparam int POS_C1OV = 7;
    localparam int POS_C1UN = 8;
    localparam int POS_C2A = 9;
    localparam int POS_C2OV = 11;
    localparam int POS_C2UN = 12;
    localparam logic [12:0] CMP_MASK = 13'h066f;
    localparam logic [12:0] FULL_ONLY_MASK = 13'h111f;
    localparam logic [12:0] ALL_MASK = 13'h1fff;
    typedef enum logic [1:0] {
        TQD_OFF = 2'h0,
        TQD_PC2 = 2'h1,
        TQD_PC3 = 2'h2,
        TQD_PC4 = 2'h3
    } tqd_mode_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tqd_bus_s;
    // events from the compare logic of the timer: ch0 a-d, ch1 a-b, ch2 a-b
    typedef struct packed {
        logic [7:0] cmp;
        logic ch0_ovf;
    } tqd_evt_s;
endpackage

// file: logic/tqd_phase_chan.sv
// tqd_phase_chan: two-phase decoder and 16-bit up/down counter of one channel
// assumes phase pins already synchronous to clk and rst_b already synchronised
`timescale 1ns/10ps
module tqd_phase_chan #(
    parameter int CNT_W = tqd_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire tqd_pkg::tqd_mode_e mode,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    output logic [CNT_W-1:0] count_ff,
    output logic dir_ff,
    output logic ovf,
    output logic unf
);
    logic a_ff;
    logic b_ff;
    logic up;
    logic dn;
    logic a_fall;
    logic b_fall;
    logic b_rise;

    // ==========================================
    // edge detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            a_ff <= 1'b0;
            b_ff <= 1'b0;
        end else begin
            a_ff <= phase_a;
            b_ff <= phase_b;
        end
    end

    assign a_fall = a_ff & ~phase_a;
    assign b_fall = b_ff & ~phase_b;
    assign b_rise = ~b_ff & phase_b;

    // ==========================================
    // count conditions per mode
    always_comb begin
        up = 1'b0;
        dn = 1'b0;
        case (mode)
            tqd_pkg::TQD_PC2: begin
                up = a_fall & phase_b;
                dn = a_fall & ~phase_b;
            end
            tqd_pkg::TQD_PC3: begin
                up = a_fall & phase_b;
                dn = b_fall & phase_a;
            end
            tqd_pkg::TQD_PC4: begin
                up = (b_rise & phase_a) | (b_fall & ~phase_a);
                dn = (b_fall & phase_a) | (b_rise & ~phase_a);
            end
            default: begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
    end

    // a counter write wins over a count in the same cycle
    assign ovf = up & ~load & (count_ff == {CNT_W{1'b1}});
    assign unf = dn & ~load & (count_ff == {CNT_W{1'b0}});

    // ==========================================
    // counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= CNT_W'(tqd_pkg::RST_CNT);
        end else if (load) begin
            count_ff <= load_val;
        end else if (up) begin
            count_ff <= count_ff + CNT_W'(1);
        end else if (dn) begin
            count_ff <= count_ff - CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_ff <= 1'b0;
        end else if (up | dn) begin
            dir_ff <= up;
        end
    end
endmodule

// file: logic/tqd_top.sv
// tqd_top: phase counting on channels 1 and 2, status flags, interrupt,
// transfer controller and converter start requests of the three-channel timer
// assumes compare events arrive as one-cycle pulses from the timer core
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module tqd_top #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int CNT_W = tqd_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire tqd_pkg::tqd_bus_s bus,
    output logic [31:0] rdata_ff,
    input wire logic ch1_phase_a_in,
    input wire logic ch1_phase_b_in,
    input wire logic ch2_phase_a_in,
    input wire logic ch2_phase_b_in,
    input wire tqd_pkg::tqd_evt_s evt,
    input wire logic [tqd_pkg::NCMP-1:0] dtc_ack,
    output logic [tqd_pkg::NSRC-1:0] irq_ff,
    output logic irq_any_ff,
    output logic [3:0] irq_top_id_ff,
    output logic [tqd_pkg::NCMP-1:0] dtc_req_ff,
    output logic [2:0] adc_start_ff
);
    if (CNT_W != 16) begin : g_chk
        $error("tqd_top: counter width must be 16");
    end

    localparam logic [12:0] VALID =
        FULL_VARIANT ? tqd_pkg::ALL_MASK : (tqd_pkg::ALL_MASK & ~tqd_pkg::FULL_ONLY_MASK);

    logic srst_a_ff;
    logic srst_b_ff;
    logic [3:0] mode_ff;
    logic [12:0] irq_en_ff;
    logic [12:0] status_ff;
    logic [12:0] seen_ff;
    logic [2:0] adc_en_ff;
    logic [12:0] set_vec;
    logic [12:0] ack_vec;
    logic [12:0] clr_vec;
    logic [12:0] nxt_status;
    logic [12:0] pend;
    logic [3:0] nxt_top_id;
    logic [31:0] nxt_rdata;
    logic [2:0] nxt_adc;
    logic wr_mode;
    logic wr_en;
    logic wr_stat;
    logic wr_cnt1;
    logic wr_cnt2;
    logic wr_adc;
    logic rd_stat;
    logic [CNT_W-1:0] cnt1;
    logic [CNT_W-1:0] cnt2;
    logic dir1;
    logic dir2;
    logic ovf1;
    logic ovf2;
    logic unf1;
    logic unf2;
    tqd_pkg::tqd_mode_e mode1;
    tqd_pkg::tqd_mode_e mode2;

    // ==========================================
    // reset release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            srst_a_ff <= 1'b0;
            srst_b_ff <= 1'b0;
        end else begin
            srst_a_ff <= 1'b1;
            srst_b_ff <= srst_a_ff;
        end
    end

    // ==========================================
    // address decode
    always_comb begin
        wr_mode = 1'b0;
        wr_en = 1'b0;
        wr_stat = 1'b0;
        wr_cnt1 = 1'b0;
        wr_cnt2 = 1'b0;
        wr_adc = 1'b0;
        if (!bus.wr) begin
            wr_mode = 1'b0;
        end else if (bus.addr == tqd_pkg::OFS_MODE) begin
            wr_mode = 1'b1;
        end else if (bus.addr == tqd_pkg::OFS_IRQ_EN) begin
            wr_en = 1'b1;
        end else if (bus.addr == tqd_pkg::OFS_STATUS) begin
            wr_stat = 1'b1;
        end else if (bus.addr == tqd_pkg::OFS_CNT1) begin
            wr_cnt1 = 1'b1;
        end else if (bus.addr == tqd_pkg::OFS_CNT2) begin
            wr_cnt2 = 1'b1;
        end else if (bus.addr == tqd_pkg::OFS_ADC_EN) begin
            wr_adc = 1'b1;
        end
    end

    assign rd_stat = bus.rd && (bus.addr == tqd_pkg::OFS_STATUS);

    // ==========================================
    // control registers
    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            mode_ff <= tqd_pkg::RST_MODE;
        end else if (wr_mode && FULL_VARIANT) begin
            mode_ff <= bus.wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            irq_en_ff <= tqd_pkg::RST_IRQ_EN;
        end else if (wr_en) begin
            irq_en_ff <= bus.wdata[12:0] & VALID;
        end
    end

    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            adc_en_ff <= tqd_pkg::RST_ADC_EN;
        end else if (wr_adc) begin
            adc_en_ff <= bus.wdata[2:0] & {2'h3, FULL_VARIANT};
        end
    end

    assign mode1 = tqd_pkg::tqd_mode_e'(mode_ff[tqd_pkg::POS_MODE1 +: 2]);
    assign mode2 = tqd_pkg::tqd_mode_e'(mode_ff[tqd_pkg::POS_MODE2 +: 2]);

    // ==========================================
    // phase counters of channels 1 and 2
    tqd_phase_chan #(.CNT_W(CNT_W)) u_ch1 (
        .clk(clk),
        .rst_b(srst_b_ff),
        .mode(mode1),
        .phase_a(ch1_phase_a_in),
        .phase_b(ch1_phase_b_in),
        .load(wr_cnt1),
        .load_val(bus.wdata[CNT_W-1:0]),
        .count_ff(cnt1),
        .dir_ff(dir1),
        .ovf(ovf1),
        .unf(unf1)
    );

    tqd_phase_chan #(.CNT_W(CNT_W)) u_ch2 (
        .clk(clk),
        .rst_b(srst_b_ff),
        .mode(mode2),
        .phase_a(ch2_phase_a_in),
        .phase_b(ch2_phase_b_in),
        .load(wr_cnt2),
        .load_val(bus.wdata[CNT_W-1:0]),
        .count_ff(cnt2),
        .dir_ff(dir2),
        .ovf(ovf2),
        .unf(unf2)
    );

    // ==========================================
    // status flags
    // source order is the fixed priority order, channel 0 first
    assign set_vec = {unf2, ovf2, evt.cmp[7:6], unf1, ovf1, evt.cmp[5:4],
        evt.ch0_ovf, evt.cmp[3:0]} & VALID;
    // the transfer controller only ever serves compare sources
    assign ack_vec = FULL_VARIANT ? ({2'h0, dtc_ack[7:6], 2'h0, dtc_ack[5:4],
        1'b0, dtc_ack[3:0]} & tqd_pkg::CMP_MASK) : 13'h0000;
    // a 0 written clears only a flag that was read as 1
    assign clr_vec = wr_stat ? (seen_ff & ~bus.wdata[12:0]) : 13'h0000;
    // a new event wins over a clear in the same cycle
    assign nxt_status = (status_ff & ~clr_vec & ~ack_vec) | set_vec;

    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            status_ff <= tqd_pkg::RST_STATUS;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            seen_ff <= tqd_pkg::RST_STATUS;
        end else if (rd_stat) begin
            seen_ff <= (seen_ff | status_ff) & nxt_status;
        end else if (wr_stat) begin
            seen_ff <= seen_ff & bus.wdata[12:0] & nxt_status;
        end else begin
            // a flag cleared by the transfer controller must be read again
            seen_ff <= seen_ff & nxt_status;
        end
    end

    // ==========================================
    // request outputs
    assign pend = status_ff & irq_en_ff;

    always_comb begin
        nxt_top_id = 4'hf;
        for (int i = tqd_pkg::NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                nxt_top_id = 4'(i);
            end
        end
    end

    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            irq_ff <= 13'h0000;
            irq_any_ff <= 1'b0;
            irq_top_id_ff <= 4'hf;
        end else begin
            irq_ff <= pend;
            irq_any_ff <= |pend;
            irq_top_id_ff <= nxt_top_id;
        end
    end

    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            dtc_req_ff <= 8'h00;
        end else if (FULL_VARIANT) begin
            dtc_req_ff <= {pend[10:9], pend[6:5], pend[3:0]};
        end else begin
            dtc_req_ff <= 8'h00;
        end
    end

    // conversion start pulse on each compare a event of an enabled channel
    assign nxt_adc = {set_vec[tqd_pkg::POS_C2A], set_vec[tqd_pkg::POS_C1A],
        set_vec[0]} & adc_en_ff;

    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            adc_start_ff <= 3'h0;
        end else begin
            adc_start_ff <= nxt_adc;
        end
    end

    // ==========================================
    // read data
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (!bus.rd) begin
            nxt_rdata = 32'h0000_0000;
        end else if (bus.addr == tqd_pkg::OFS_MODE) begin
            nxt_rdata = {26'h0, dir2, dir1, mode_ff};
        end else if (bus.addr == tqd_pkg::OFS_IRQ_EN) begin
            nxt_rdata = {19'h0, irq_en_ff};
        end else if (bus.addr == tqd_pkg::OFS_STATUS) begin
            nxt_rdata = {19'h0, status_ff};
        end else if (bus.addr == tqd_pkg::OFS_CNT1) begin
            nxt_rdata = {16'h0, cnt1};
        end else if (bus.addr == tqd_pkg::OFS_CNT2) begin
            nxt_rdata = {16'h0, cnt2};
        end else if (bus.addr == tqd_pkg::OFS_ADC_EN) begin
            nxt_rdata = {29'h0, adc_en_ff};
        end else if (bus.addr == tqd_pkg::OFS_PEND) begin
            nxt_rdata = {19'h0, pend};
        end
    end

    always_ff @(posedge clk or negedge srst_b_ff) begin
        if (!srst_b_ff) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!srst_b_ff);

    sequence s_c1_a_fall_bh;
        ch1_phase_a_in ##1 (!ch1_phase_a_in && ch1_phase_b_in && mode1 == tqd_pkg::TQD_PC2
            && !wr_cnt1);
    endsequence

    sequence s_c1_b_fall_ah;
        ch1_phase_b_in ##1 (!ch1_phase_b_in && ch1_phase_a_in && mode1 == tqd_pkg::TQD_PC3
            && !wr_cnt1);
    endsequence

    sequence s_c1_a_only;
        (mode1 == tqd_pkg::TQD_PC4 && !wr_cnt1 && $stable(ch1_phase_b_in)) [*2];
    endsequence

    a_pc2_up_count: assert property (
        s_c1_a_fall_bh |=> cnt1 == CNT_W'($past(cnt1) + CNT_W'(1)))
        else $error("mode 2 up count missed");

    a_pc3_down_count: assert property (
        s_c1_b_fall_ah |=> cnt1 == CNT_W'($past(cnt1) - CNT_W'(1)))
        else $error("mode 3 down count missed");

    a_pc4_a_ignored: assert property (
        s_c1_a_only |=> $stable(cnt1))
        else $error("mode 4 counted without a b edge");

    a_wrap_ovf_flag: assert property (
        (ovf1 && !wr_stat) |=> cnt1 == {CNT_W{1'b0}} && status_ff[tqd_pkg::POS_C1OV])
        else $error("overflow wrap or flag wrong");

    a_irq_follows: assert property (
        ##1 irq_ff == $past(status_ff & irq_en_ff))
        else $error("request does not follow flag and enable");

    a_irq_withdraw: assert property (
        $fell(status_ff[tqd_pkg::POS_C1A]) |=> !irq_ff[tqd_pkg::POS_C1A])
        else $error("request not withdrawn after clear");

    a_set_wins: assert property (
        (evt.cmp[4] && wr_stat && !bus.wdata[tqd_pkg::POS_C1A])
        |=> status_ff[tqd_pkg::POS_C1A])
        else $error("event lost against a clear");

    a_clear_needs_read: assert property (
        (status_ff[tqd_pkg::POS_C1OV] && !seen_ff[tqd_pkg::POS_C1OV] && !ack_vec[7])
        |=> status_ff[tqd_pkg::POS_C1OV])
        else $error("flag cleared without a prior read");

    a_dtc_cmp_only: assert property (
        ##1 dtc_req_ff == (FULL_VARIANT ? $past({pend[10:9], pend[6:5], pend[3:0]}) : 8'h00))
        else $error("transfer request from a wrong source");

    a_adc_cause: assert property (
        adc_start_ff[1] |-> $past(evt.cmp[4] && adc_en_ff[1]))
        else $error("conversion start without compare a");

    a_reduced_srcs: assert property (
        !FULL_VARIANT |-> (irq_ff & tqd_pkg::FULL_ONLY_MASK) == 13'h0000)
        else $error("reduced variant raised a full-only source");

    a_top_priority: assert property (
        irq_any_ff |-> irq_ff[irq_top_id_ff] && (irq_ff & ((13'h0001 << irq_top_id_ff)
            - 13'h0001)) == 13'h0000)
        else $error("highest priority source not reported");
endmodule

// file: testbench/tqd_far_model.sv
// tqd_far_model: encoder pins and conversion start sink outside the timer
// assumes toggle requests come one cycle long, spaced by the caller
`timescale 1ns/10ps
module tqd_far_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] tgl,
    input wire logic [2:0] adc_start,
    input wire logic [2:0] trig_sel,
    output logic [3:0] pins,
    output int conv_cnt
);
    // ==========================================
    // encoder: pin order ch1 a, ch1 b, ch2 a, ch2 b
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pins <= 4'h0;
        end else begin
            pins <= pins ^ tgl;
        end
    end
    // ==========================================
    // converter: starts only on channels chosen as trigger
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_cnt <= 0;
        end else begin
            conv_cnt <= conv_cnt + $countones(adc_start & trig_sel);
        end
    end
endmodule

// file: testbench/testbench.sv
// testbench: self-checking bench of tqd_top against an integer model
// assumes tqd_pkg compiled first and tqd_far_model beside it
`timescale 1ns/10ps
module testbench;
    localparam int CMAX = (1 << tqd_pkg::CNT_W) - 1;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    tqd_pkg::tqd_bus_s bus = '0;
    tqd_pkg::tqd_evt_s evt = '0;
    logic [7:0] dtc_ack = 8'h00;
    logic [3:0] tgl = 4'h0;
    logic [2:0] trig_sel = 3'h0;
    logic [3:0] pins;
    logic [31:0] rdata_ff;
    logic [12:0] irq_ff;
    logic irq_any_ff;
    logic [3:0] irq_top_id_ff;
    logic [7:0] dtc_req_ff;
    logic [2:0] adc_start_ff;
    int conv_cnt;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 32'hf7fb;
    int cnt[2];
    int m_conv = 0;
    int src_of[9] = '{0, 1, 2, 3, 5, 6, 9, 10, 4};
    logic [12:0] m_st = '0;
    logic [12:0] m_en = '0;
    logic [2:0] m_adc = '0;
    logic [31:0] r;
    always #50 clk = ~clk;
    tqd_top #(.FULL_VARIANT(1'b1), .CNT_W(16)) u_dut (
        .clk(clk), .rst_b(rst_b), .bus(bus), .rdata_ff(rdata_ff),
        .ch1_phase_a_in(pins[0]), .ch1_phase_b_in(pins[1]),
        .ch2_phase_a_in(pins[2]), .ch2_phase_b_in(pins[3]),
        .evt(evt), .dtc_ack(dtc_ack), .irq_ff(irq_ff), .irq_any_ff(irq_any_ff),
        .irq_top_id_ff(irq_top_id_ff), .dtc_req_ff(dtc_req_ff), .adc_start_ff(adc_start_ff)
    );
    tqd_far_model u_far (
        .clk(clk), .rst_b(rst_b), .tgl(tgl), .adc_start(adc_start_ff),
        .trig_sel(trig_sel), .pins(pins), .conv_cnt(conv_cnt)
    );
    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(nm, rdata_ff, exp);
    endtask
    function automatic int dlt(int md, logic oa, logic ob, logic na, logic nb);
        logic af, bf, br;
        af = oa & !na;
        bf = ob & !nb;
        br = !ob & nb;
        case (md)
            1: return af ? (nb ? 1 : -1) : 0;
            2: return (af && nb) ? 1 : ((bf && na) ? -1 : 0);
            3: return br ? (na ? 1 : -1) : (bf ? (na ? -1 : 1) : 0);
            default: return 0;
        endcase
    endfunction
    task automatic step(input int ch, input int pin, input int md);
        logic oa, ob;
        int c;
        oa = pins[2*ch];
        ob = pins[2*ch+1];
        @(posedge clk);
        tgl[2*ch+pin] <= 1'b1;
        @(posedge clk);
        tgl <= 4'h0;
        #1;
        c = cnt[ch] + dlt(md, oa, ob, pins[2*ch], pins[2*ch+1]);
        if (c > CMAX) begin
            c = 0;
            m_st[7+4*ch] = 1'b1;
        end
        if (c < 0) begin
            c = CMAX;
            m_st[8+4*ch] = 1'b1;
        end
        cnt[ch] = c;
        repeat (3) @(posedge clk);
    endtask
    task automatic chk_irq;
        logic [12:0] p;
        logic [7:0] q;
        int top;
        p = m_st & m_en;
        top = 15;
        for (int k = 12; k >= 0; k--) if (p[k]) top = k;
        for (int j = 0; j < 8; j++) q[j] = p[src_of[j]];
        chk("irq", irq_ff, p);
        chk("irq_any", irq_any_ff, |p);
        chk("top_id", irq_top_id_ff, top[3:0]);
        chk("dtc_req", dtc_req_ff, q);
    endtask
    task automatic pulse(input int i);
        logic [2:0] a;
        @(posedge clk);
        evt <= tqd_pkg::tqd_evt_s'((i == 8) ? 9'h001 : (9'h002 << i));
        @(posedge clk);
        evt <= '0;
        #1;
        a = {i == 6, i == 4, i == 0} & m_adc;
        m_st[src_of[i]] = 1'b1;
        m_conv += $countones(a & trig_sel);
        chk("adc_start", adc_start_ff, a);
        @(posedge clk);
        #1 chk_irq();
    endtask
    task automatic ack(input int i);
        @(posedge clk);
        dtc_ack[i] <= 1'b1;
        @(posedge clk);
        dtc_ack <= 8'h00;
        m_st[src_of[i]] = 1'b0;
        @(posedge clk);
        #1 chk_irq();
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 8; k++) rd("reset_reg", 8'(4 * k), 32'h0);
        $display("reset values done");
        m_en = tqd_pkg::ALL_MASK;
        wr(tqd_pkg::OFS_IRQ_EN, m_en);
        rd("irq_en", tqd_pkg::OFS_IRQ_EN, m_en);
        for (int md = 0; md < 4; md++) begin
            wr(tqd_pkg::OFS_MODE, md | (md << 2));
            for (int ch = 0; ch < 2; ch++) begin
                r = $random(seed);
                cnt[ch] = r[1] ? (r[0] ? CMAX : 0) : r[31:16];
                wr(ch ? tqd_pkg::OFS_CNT2 : tqd_pkg::OFS_CNT1, cnt[ch]);
            end
            repeat (16) begin
                r = $random(seed);
                step(r[0], r[1], md);
            end
            rd("cnt1", tqd_pkg::OFS_CNT1, cnt[0]);
            rd("cnt2", tqd_pkg::OFS_CNT2, cnt[1]);
            rd("status", tqd_pkg::OFS_STATUS, m_st);
            chk_irq();
            wr(tqd_pkg::OFS_STATUS, 32'h0);
            m_st = '0;
        end
        $display("phase counting done");
        r = $random(seed);
        m_en = r[12:0];
        m_adc = r[15:13];
        trig_sel <= r[18:16];
        wr(tqd_pkg::OFS_IRQ_EN, m_en);
        wr(tqd_pkg::OFS_ADC_EN, m_adc);
        for (int i = 0; i < 9; i++) pulse(i);
        chk("conv_cnt", conv_cnt, m_conv);
        wr(tqd_pkg::OFS_PEND, 32'hffff);
        rd("pend", tqd_pkg::OFS_PEND, m_st & m_en);
        wr(tqd_pkg::OFS_STATUS, 32'h0);
        rd("status_unread", tqd_pkg::OFS_STATUS, m_st);
        for (int i = 0; i < 4; i++) ack(i);
        rd("status_acked", tqd_pkg::OFS_STATUS, m_st);
        // clear every read flag while a ch1 compare a event lands in the same cycle
        @(posedge clk);
        evt <= tqd_pkg::tqd_evt_s'(9'h020);
        bus.addr <= tqd_pkg::OFS_STATUS;
        bus.wdata <= 32'h0;
        bus.wr <= 1'b1;
        @(posedge clk);
        evt <= '0;
        bus.wr <= 1'b0;
        m_st = 13'h0020;
        @(posedge clk);
        #1 chk_irq();
        rd("status_set_wins", tqd_pkg::OFS_STATUS, m_st);
        wr(tqd_pkg::OFS_STATUS, 32'h0);
        m_st = '0;
        @(posedge clk);
        #1 chk_irq();
        $display("events and flags done");
        summarize();
    end
endmodule
